// ### core/aic_channel.v
`timescale 1ns/10ps
`include "aic_regs.vh"
module aic_channel (
  input wire pclk,
  input wire presetn,
  input wire tick,
  input wire signed [15:0] sample,
  input wire [2:0] sig_type,
  input wire [15:0] time_const,
  input wire [15:0] phys_lo,
  input wire [15:0] phys_hi,
  input wire [15:0] bip_span,
  input wire bip_ok,
  input wire signed [31:0] y_lo,
  input wire signed [31:0] y_hi,
  output reg signed [31:0] scaled_out,
  output reg low_signal
);
reg signed [31:0] filt_reg;
reg signed [16:0] lo;
reg signed [16:0] hi;
reg signed [16:0] s;
reg signed [16:0] smin;
reg signed [16:0] smax;
reg signed [31:0] yl;
reg bip;
reg [15:0] lim;
wire signed [31:0] x_q;
wire signed [31:0] step;
wire signed [16:0] den;
wire signed [47:0] num;
wire signed [47:0] res;

////////////////////////////////////////////////////////////////
// first-order lag
// Fixed point, 16 fraction bits; one step per millisecond tick
assign x_q = {sample, 16'h0000};
assign step = (x_q - filt_reg) / $signed({16'h0000, time_const});
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    filt_reg <= 32'h0000_0000;
  else if (tick)
    filt_reg <= filt_reg + step;
end

////////////////////////////////////////////////////////////////
always @*
begin
  lim = sig_type[`AIC_T_VOLT_BIT] ? `AIC_VOLT_MAX : `AIC_CUR_MAX;
  bip = 1'b0;
  case (sig_type)
    `AIC_T_CUR_LZ:
    begin
      lo = {1'b0, `AIC_CUR_LZ};
      hi = {1'b0, `AIC_CUR_MAX};
    end
    `AIC_T_CUR_FS:
    begin
      lo = 17'h0_0000;
      hi = {1'b0, `AIC_CUR_MAX};
    end
    `AIC_T_VOLT_FS:
    begin
      lo = 17'h0_0000;
      hi = {1'b0, `AIC_VOLT_MAX};
    end
    `AIC_T_VOLT_LZ:
    begin
      lo = {1'b0, `AIC_VOLT_LZ};
      hi = {1'b0, `AIC_VOLT_MAX};
    end
    `AIC_T_CUR_BIP, `AIC_T_VOLT_BIP:
    begin
      bip = 1'b1;
      hi = {1'b0, (bip_span > lim) ? lim : bip_span};
      lo = -hi;
    end
    default:
    begin
      lo = {1'b0, (phys_lo > lim) ? lim : phys_lo};
      hi = {1'b0, (phys_hi > lim) ? lim : phys_hi};
    end
  endcase
  // inverted span needs only ordered clamp bounds
  smin = (lo < hi) ? lo : hi;
  smax = (lo < hi) ? hi : lo;
  s = {filt_reg[31], filt_reg[31:16]};
  // negative side only with both directions allowed
  if (s < 17'sh0_0000 && !(bip && bip_ok))
    s = 17'h0_0000;
  if (s < smin)
    s = smin;
  if (s > smax)
    s = smax;
  yl = bip ? -y_hi : y_lo;
end

////////////////////////////////////////////////////////////////
// linear interpolation
assign den = hi - lo;
assign num = (s - lo) * (y_hi - yl);
assign res = (den == 17'h0_0000) ? yl : yl + num / den;
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    scaled_out <= 32'h0000_0000;
    low_signal <= 1'b0;
  end
  else
  begin
    scaled_out <= res[31:0];
    // below 75% of minimum
    // Signed compare so a negative sample still counts as low
    low_signal <= !bip && ($signed({filt_reg[31:16], 2'b00}) <
      $signed({smin, 1'b0}) + $signed({smin[16], smin}));
  end
end
endmodule // aic_channel

// ### core/aic_regs.vh
`ifndef AIC_REGS_VH
`define AIC_REGS_VH

// Timing
`define AIC_CLK_NS 5
`define AIC_TICK_NS 1000000
// Address: block in [8:6], word in [5:2]
`define AIC_F_BLK 8:6
`define AIC_F_WORD 5:2
`define AIC_F_HIGH 11:9
`define AIC_BLK_GLB 3'h4
`define AIC_W_CFG 4'h0
`define AIC_W_PLO 4'h1
`define AIC_W_PHI 4'h2
`define AIC_W_BIP 4'h3
`define AIC_W_ULO 4'h4
`define AIC_W_UHI 4'h5
`define AIC_W_TC 4'h6
`define AIC_W_VAL 4'h7
`define AIC_W_SUP 4'h0
`define AIC_W_STAT 4'h1
// Channel configuration fields
`define AIC_F_FUNC 2:0
`define AIC_F_TYPE 6:4
`define AIC_F_LSEL 9:8
`define AIC_F_HSEL 11:10
`define AIC_F_SIGN 12
`define AIC_F_GATE 15:14
// Reset values
`define AIC_CFG_RST_FIRST 16'h0404
`define AIC_CFG_RST_OTHER 16'h0400
`define AIC_PLO_RST 16'h0190
`define AIC_PHI_RST 16'h07D0
`define AIC_BIP_RST 16'h07D0
`define AIC_TC_RST 16'h0064
// Ranges in 0.01 mA or 0.01 V, time constant in ms
`define AIC_CUR_MAX 16'h07D0
`define AIC_VOLT_MAX 16'h03E8
`define AIC_CUR_LZ 16'h0190
`define AIC_VOLT_LZ 16'h00C8
`define AIC_TC_MIN 16'h0001
`define AIC_TC_MAX 16'h2710
`define AIC_USER_MAX 32'h0098_9680
// Function codes
`define AIC_FN_OFF 3'h0
`define AIC_FN_MAXSPD 3'h1
`define AIC_FN_MAXTRQ 3'h2
`define AIC_FN_PVAL 3'h3
`define AIC_FN_PREF 3'h4
`define AIC_FN_MINSPD 3'h5
// Signal types
`define AIC_T_CUR_LZ 3'h0
`define AIC_T_CUR_FS 3'h1
`define AIC_T_CUR_USR 3'h2
`define AIC_T_CUR_BIP 3'h3
`define AIC_T_VOLT_FS 3'h4
`define AIC_T_VOLT_LZ 3'h5
`define AIC_T_VOLT_USR 3'h6
`define AIC_T_VOLT_BIP 3'h7
`define AIC_T_VOLT_BIT 2
// Selectors
`define AIC_SEL_MIN 2'h0
`define AIC_SEL_MAX 2'h1
`define AIC_SEL_USER 2'h2
`define AIC_GATE_ON 2'h0
`define AIC_GATE_LOW 2'h1
`define AIC_GATE_HIGH 2'h2
`define AIC_SUP_OFF 2'h0
`define AIC_SUP_TRIP 2'h1
`define AIC_SUP_WARN 2'h2
`endif

// ### core/aic_top.v
`timescale 1ns/10ps
`include "aic_regs.vh"
module aic_top #(
  parameter TICK_CYCLES = `AIC_TICK_NS / `AIC_CLK_NS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [15:0] sample_0,
  input wire [15:0] sample_1,
  input wire [15:0] sample_2,
  input wire [15:0] sample_3,
  input wire selector_input,
  input wire run_right_command,
  input wire run_left_command,
  input wire rotation_both_ways,
  input wire [31:0] speed_min_limit,
  input wire [31:0] speed_max_limit,
  input wire [31:0] torque_max_limit,
  input wire [31:0] process_min_limit,
  input wire [31:0] process_max_limit,
  output reg [31:0] max_speed_sum,
  output reg [31:0] max_torque_sum,
  output reg [31:0] process_value_sum,
  output reg [31:0] process_ref_sum,
  output reg [31:0] min_speed_sum,
  output reg supervision_trip,
  output reg supervision_warning
);
reg [15:0] cfg_reg [0:3];
reg [15:0] plo_reg [0:3];
reg [15:0] phi_reg [0:3];
reg [15:0] bip_reg [0:3];
reg [31:0] ulo_reg [0:3];
reg [31:0] uhi_reg [0:3];
reg [15:0] tc_reg [0:3];
reg [1:0] sup_reg;
reg [3:0] trip_reg;
reg [3:0] warn_reg;
reg [17:0] tick_cnt_reg;
reg tick_reg;
reg [31:0] ylo_c [0:3];
reg [31:0] yhi_c [0:3];
reg [3:0] active;
reg [31:0] sum_next [1:5];
reg [31:0] rd_next;
wire [31:0] scaled [0:3];
wire [3:0] low_sig;
wire [15:0] smp [0:3];
wire [2:0] blk;
wire [3:0] wd;
wire mapped;
wire wr_en;
wire bip_ok;
wire [3:0] qual_low;
integer i;
integer c, k, r;

////////////////////////////////////////////////////////////////
// Clamp helpers for register writes
function [15:0] clip_phys;
  input [31:0] v;
  begin
    clip_phys = (v > {16'h0000, `AIC_CUR_MAX}) ? `AIC_CUR_MAX : v[15:0];
  end
endfunction
function [15:0] clip_tc;
  input [31:0] v;
  begin
    if (v < {16'h0000, `AIC_TC_MIN})
      clip_tc = `AIC_TC_MIN;
    else if (v > {16'h0000, `AIC_TC_MAX})
      clip_tc = `AIC_TC_MAX;
    else
      clip_tc = v[15:0];
  end
endfunction
function [31:0] clip_user;
  input [31:0] v;
  begin
    if ($signed(v) > $signed(`AIC_USER_MAX))
      clip_user = `AIC_USER_MAX;
    else if ($signed(v) < -$signed(`AIC_USER_MAX))
      clip_user = -`AIC_USER_MAX;
    else
      clip_user = v;
  end
endfunction
// selector decode; limits per function
// Limits come in as arguments so the caller's sensitivity sees them
function [31:0] pick;
  input [1:0] sel;
  input [2:0] fn;
  input [31:0] user;
  input [31:0] spd_lo, spd_hi, trq_hi, prc_lo, prc_hi;
  reg [31:0] fmin;
  reg [31:0] fmax;
  begin
    case (fn)
      `AIC_FN_MAXSPD, `AIC_FN_MINSPD:
      begin
        fmin = spd_lo;
        fmax = spd_hi;
      end
      `AIC_FN_MAXTRQ:
      begin
        fmin = 32'h0000_0000;
        fmax = trq_hi;
      end
      `AIC_FN_PVAL, `AIC_FN_PREF:
      begin
        fmin = prc_lo;
        fmax = prc_hi;
      end
      default:
      begin
        fmin = 32'h0000_0000;
        fmax = 32'h0000_0000;
      end
    endcase
    case (sel)
      `AIC_SEL_MIN: pick = fmin;
      `AIC_SEL_MAX: pick = fmax;
      `AIC_SEL_USER: pick = user;
      default: pick = fmin;
    endcase
  end
endfunction

////////////////////////////////////////////////////////////////
// Millisecond tick for the smoothing filters
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    tick_cnt_reg <= 18'h0_0000;
    tick_reg <= 1'b0;
  end
  else if (tick_cnt_reg == TICK_CYCLES - 1)
  begin
    tick_cnt_reg <= 18'h0_0000;
    tick_reg <= 1'b1;
  end
  else
  begin
    tick_cnt_reg <= tick_cnt_reg + 18'h0_0001;
    tick_reg <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////
// APB slave: zero wait states
assign blk = paddr[`AIC_F_BLK];
assign wd = paddr[`AIC_F_WORD];
assign mapped = (paddr[`AIC_F_HIGH] == 3'h0) && (paddr[1:0] == 2'h0) &&
  ((blk < `AIC_BLK_GLB && wd <= `AIC_W_VAL) ||
  (blk == `AIC_BLK_GLB && wd <= `AIC_W_STAT));
assign pready = 1'b1;
assign pslverr = psel && penable && !mapped;
assign wr_en = psel && penable && pwrite && mapped;

always @*
begin
  rd_next = 32'h0000_0000;
  if (blk == `AIC_BLK_GLB)
  begin
    if (wd == `AIC_W_SUP)
      rd_next = {30'h0000_0000, sup_reg};
    else if (wd == `AIC_W_STAT)
      rd_next = {20'h0_0000, qual_low, warn_reg, trip_reg};
  end
  else if (blk < `AIC_BLK_GLB)
  begin
    case (wd)
      `AIC_W_CFG: rd_next = {16'h0000, cfg_reg[blk[1:0]]};
      `AIC_W_PLO: rd_next = {16'h0000, plo_reg[blk[1:0]]};
      `AIC_W_PHI: rd_next = {16'h0000, phi_reg[blk[1:0]]};
      `AIC_W_BIP: rd_next = {16'h0000, bip_reg[blk[1:0]]};
      `AIC_W_ULO: rd_next = ulo_reg[blk[1:0]];
      `AIC_W_UHI: rd_next = uhi_reg[blk[1:0]];
      `AIC_W_TC: rd_next = {16'h0000, tc_reg[blk[1:0]]};
      `AIC_W_VAL: rd_next = scaled[blk[1:0]];
      default: rd_next = 32'h0000_0000;
    endcase
  end
end

// Read data captured in setup so it stands through the access
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
    prdata <= 32'h0000_0000;
  else if (psel && !penable && !pwrite)
    prdata <= mapped ? rd_next : 32'h0000_0000;
end

////////////////////////////////////////////////////////////////
// Register file
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    for (r = 0; r < 4; r = r + 1)
    begin
      cfg_reg[r] <= (r == 0) ? `AIC_CFG_RST_FIRST : `AIC_CFG_RST_OTHER;
      plo_reg[r] <= `AIC_PLO_RST;
      phi_reg[r] <= `AIC_PHI_RST;
      bip_reg[r] <= `AIC_BIP_RST;
      ulo_reg[r] <= 32'h0000_0000;
      uhi_reg[r] <= 32'h0000_0000;
      tc_reg[r] <= `AIC_TC_RST;
    end
    sup_reg <= `AIC_SUP_OFF;
  end
  else if (wr_en)
  begin
    if (blk == `AIC_BLK_GLB)
    begin
      if (wd == `AIC_W_SUP)
        sup_reg <= pwdata[1:0];
    end
    else
    begin
      case (wd)
        `AIC_W_CFG: cfg_reg[blk[1:0]] <= pwdata[15:0];
        `AIC_W_PLO: plo_reg[blk[1:0]] <= clip_phys(pwdata);
        `AIC_W_PHI: phi_reg[blk[1:0]] <= clip_phys(pwdata);
        `AIC_W_BIP: bip_reg[blk[1:0]] <= clip_phys(pwdata);
        `AIC_W_ULO: ulo_reg[blk[1:0]] <= clip_user(pwdata);
        `AIC_W_UHI: uhi_reg[blk[1:0]] <= clip_user(pwdata);
        `AIC_W_TC: tc_reg[blk[1:0]] <= clip_tc(pwdata);
        default: tc_reg[blk[1:0]] <= tc_reg[blk[1:0]];
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////
// Channels
assign smp[0] = sample_0;
assign smp[1] = sample_1;
assign smp[2] = sample_2;
assign smp[3] = sample_3;
assign bip_ok = run_right_command && run_left_command && rotation_both_ways;

always @*
begin
  for (c = 0; c < 4; c = c + 1)
  begin
    ylo_c[c] = pick(cfg_reg[c][`AIC_F_LSEL], cfg_reg[c][`AIC_F_FUNC],
      ulo_reg[c], speed_min_limit, speed_max_limit, torque_max_limit,
      process_min_limit, process_max_limit);
    yhi_c[c] = pick(cfg_reg[c][`AIC_F_HSEL], cfg_reg[c][`AIC_F_FUNC],
      uhi_reg[c], speed_min_limit, speed_max_limit, torque_max_limit,
      process_min_limit, process_max_limit);
    case (cfg_reg[c][`AIC_F_GATE])
      `AIC_GATE_ON: active[c] = 1'b1;
      `AIC_GATE_LOW: active[c] = !selector_input;
      `AIC_GATE_HIGH: active[c] = selector_input;
      default: active[c] = 1'b0;
    endcase
    if (cfg_reg[c][`AIC_F_FUNC] == `AIC_FN_OFF)
      active[c] = 1'b0;
  end
end

genvar g;
generate
  for (g = 0; g < 4; g = g + 1)
  begin : ch
    aic_channel u_chan (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick_reg),
      .sample(smp[g]),
      .sig_type(cfg_reg[g][`AIC_F_TYPE]),
      .time_const(tc_reg[g]),
      .phys_lo(plo_reg[g]),
      .phys_hi(phi_reg[g]),
      .bip_span(bip_reg[g]),
      .bip_ok(bip_ok),
      .y_lo(ylo_c[g]),
      .y_hi(yhi_c[g]),
      .scaled_out(scaled[g]),
      .low_signal(low_sig[g])
    );
  end
endgenerate

////////////////////////////////////////////////////////////////
// signed sum per function
always @*
begin
  for (i = 1; i < 6; i = i + 1)
  begin
    sum_next[i] = 32'h0000_0000;
    for (k = 0; k < 4; k = k + 1)
    begin
      if (active[k] && cfg_reg[k][`AIC_F_FUNC] == i[2:0])
        sum_next[i] = cfg_reg[k][`AIC_F_SIGN] ?
          sum_next[i] - scaled[k] : sum_next[i] + scaled[k];
    end
  end
end

always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    max_speed_sum <= 32'h0000_0000;
    max_torque_sum <= 32'h0000_0000;
    process_value_sum <= 32'h0000_0000;
    process_ref_sum <= 32'h0000_0000;
    min_speed_sum <= 32'h0000_0000;
  end
  else
  begin
    max_speed_sum <= sum_next[1];
    max_torque_sum <= sum_next[2];
    process_value_sum <= sum_next[3];
    process_ref_sum <= sum_next[4];
    min_speed_sum <= sum_next[5];
  end
end

////////////////////////////////////////////////////////////////
// Low-signal supervision; a new trip beats a same-cycle clear
assign qual_low = low_sig & active;
always @(posedge pclk or negedge presetn)
begin
  if (!presetn)
  begin
    trip_reg <= 4'h0;
    warn_reg <= 4'h0;
    supervision_trip <= 1'b0;
    supervision_warning <= 1'b0;
  end
  else
  begin
    // sticky trip, write one to clear
    trip_reg <= (trip_reg & ~((wr_en && blk == `AIC_BLK_GLB &&
      wd == `AIC_W_STAT) ? pwdata[3:0] : 4'h0)) |
      ((sup_reg == `AIC_SUP_TRIP) ? qual_low : 4'h0);
    warn_reg <= (sup_reg == `AIC_SUP_WARN) ? qual_low : 4'h0;
    supervision_trip <= |trip_reg;
    supervision_warning <= |warn_reg;
  end
end
endmodule // aic_top

// ### verif/aic_sensor.sv
`timescale 1ns/10ps
module aic_sensor (
  input wire pclk,
  input wire slow,
  input wire [15:0] target,
  output logic [15:0] sample
);
  logic signed [15:0] d;
  assign d = target - sample;
  initial sample = 16'h0000;
  // Slow mode slews like a sluggish transmitter
  always @(posedge pclk)
  begin
    if (!slow || (d < 16'sh0009 && d > -16'sh0009))
      sample <= target;
    else
      sample <= sample + (d[15] ? 16'hFFF8 : 16'h0008);
  end
endmodule // aic_sensor

// ### verif/aic_top_assertions.sv
`timescale 1ns/10ps
module aic_top_assertions (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire supervision_trip,
  input wire supervision_warning
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] sup_q;
  logic [2:0] age;
  wire acc = psel && penable;
  wire wst = acc && pwrite && paddr == 12'h104;
  wire map = paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0 &&
    (paddr[8] ? paddr[7:3] == 5'h00 : !paddr[5]);
  // Age saturates so mode checks skip the pipeline flush
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sup_q <= 2'h0;
      age <= 3'h0;
    end
    else if (acc && pwrite && paddr == 12'h100)
    begin
      sup_q <= pwdata[1:0];
      age <= 3'h0;
    end
    else if (age != 3'h7)
      age <= age + 3'h1;
  end
  sequence settled(m);
    sup_q == m && age == 3'h7;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_decode: assert property (acc |-> pslverr == !map)
    else $error("slave error decode wrong");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("slave error outside access");
  a_bad_rdzero: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  a_rdata_hold: assert property
    (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without read");
  a_off_quiet: assert property (settled(2'h0) |-> !supervision_warning)
    else $error("warning with supervision off");
  a_trip_nowarn: assert property (settled(2'h1) |-> !supervision_warning)
    else $error("warning in trip mode");
  a_warn_notrip: assert property
    (sup_q != 2'h1 && age == 3'h7 |-> !$rose(supervision_trip))
    else $error("trip outside trip mode");
  a_trip_clear: assert property ($fell(supervision_trip) |->
    $past(wst, 2) || $past(wst, 3))
    else $error("trip fell without clear");
endmodule // aic_top_assertions

bind aic_top aic_top_assertions CHK (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .supervision_trip,
  .supervision_warning);

// ### verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, ms, mt, pv, pr, mn;
  logic pready, pslverr, trip, warn, sel_in = 0, slow = 0;
  logic rr = 1, rl = 1, rot = 1;
  logic [31:0] spmn = 0, spmx = 32'h0000_03E8, tqmx = 32'h0000_0190;
  logic [31:0] prmn = 0, prmx = 32'h0000_05DC;
  logic [15:0] tg [4] = '{default: 16'h0000};
  wire [15:0] smp [4];
  int n_mismatch = 0, checks = 0, cyc = 0;
  for (genvar i = 0; i < 4; i++)
  begin : g_src
    aic_sensor SRC (.pclk(pclk), .slow(slow), .target(tg[i]),
      .sample(smp[i]));
  end
  aic_top #(.TICK_CYCLES(20)) DUT (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_0(smp[0]), .sample_1(smp[1]), .sample_2(smp[2]),
    .sample_3(smp[3]), .selector_input(sel_in), .run_right_command(rr),
    .run_left_command(rl), .rotation_both_ways(rot),
    .speed_min_limit(spmn), .speed_max_limit(spmx),
    .torque_max_limit(tqmx), .process_min_limit(prmn),
    .process_max_limit(prmx), .max_speed_sum(ms), .max_torque_sum(mt),
    .process_value_sum(pv), .process_ref_sum(pr), .min_speed_sum(mn),
    .supervision_trip(trip), .supervision_warning(warn));
  always #2.5 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, x);
    checks++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h exp %h", $time, s, x);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task rv(input logic [11:0] a, input logic [31:0] x);
    apb(0, a, 0);
    chk(rd, x);
  endtask
  // One tick is 20 cycles here
  task tk(input int n);
    repeat (n * 20) @(posedge pclk);
  endtask
  function logic [31:0] cfg(input logic [2:0] f, t, input logic [1:0] l,
    h, input logic s, input logic [1:0] g);
    return {16'h0000, g, 1'b0, s, h, l, 1'b0, t, 1'b0, f};
  endfunction
  task setch(input logic [1:0] c, input logic [31:0] v,
    input logic [15:0] lo, hi);
    logic [11:0] b;
    b = {4'h0, c, 6'h00};
    wr(b, v);
    wr(b + 12'h004, {16'h0000, lo});
    wr(b + 12'h008, {16'h0000, hi});
    wr(b + 12'h018, 32'h0000_0001);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_reset;
    logic [15:0] x [7];
    x = '{16'h0404, 16'h0190, 16'h07D0, 16'h07D0, 16'h0000, 16'h0000,
      16'h0064};
    for (int i = 0; i < 7; i++)
      rv(12'(i * 4), {16'h0000, x[i]});
    rv(12'h040, 32'h0000_0400);
    rv(12'h100, 32'h0000_0000);
  endtask
  task t_err;
    apb(0, 12'h180, 32'h0000_0000);
    chk(e, 1);
    chk(rd, 0);
    apb(0, 12'h120, 32'h0000_0000);
    chk(e, 1);
    wr(12'h018, 32'h0000_0000);
    rv(12'h018, 32'h0000_0001);
    wr(12'h018, 32'h0000_4E20);
    rv(12'h018, 32'h0000_2710);
    wr(12'h004, 32'h0000_0BB8);
    rv(12'h004, 32'h0000_07D0);
  endtask
  task t_types;
    logic [15:0] s [8];
    s = '{16'h04B0, 16'h03E8, 16'h0190, 16'h03E8, 16'h01F4, 16'h0258,
      16'h0190, 16'h01F4};
    wr(12'h000, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      setch(1, cfg(3'h4, 3'(i), 2'h0, 2'h1, 0, 2'h0), 0, 16'h0320);
      tg[1] <= s[i];
      tk(3);
      chk(pr, 32'h0000_02EE);
    end
  endtask
  task t_sum;
    slow <= 1;
    setch(0, cfg(3'h4, 3'h0, 2'h0, 2'h1, 0, 2'h0), 0, 0);
    setch(1, cfg(3'h4, 3'h4, 2'h0, 2'h1, 1, 2'h0), 0, 0);
    tg[0] <= 16'h04B0;
    tg[1] <= 16'h0190;
    tk(12);
    chk(pr, 32'h0000_0096);
    rv(12'h01C, 32'h0000_02EE);
    wr(12'h040, cfg(3'h4, 3'h4, 2'h0, 2'h1, 0, 2'h0));
    tk(3);
    chk(pr, 32'h0000_0546);
    wr(12'h040, cfg(3'h3, 3'h4, 2'h0, 2'h1, 0, 2'h0));
    tk(3);
    chk(pv, 32'h0000_0258);
    chk(pr, 32'h0000_02EE);
    slow <= 0;
    wr(12'h040, 32'h0000_0000);
  endtask
  task t_func;
    wr(12'h000, 32'h0000_0000);
    spmn <= 32'h0000_0064;
    setch(2, cfg(3'h1, 3'h2, 2'h0, 2'h1, 0, 2'h0), 16'h07D0, 0);
    setch(3, cfg(3'h5, 3'h1, 2'h1, 2'h0, 0, 2'h0), 0, 0);
    tg[2] <= 16'h01F4;
    tg[3] <= 16'h03E8;
    tk(3);
    chk(ms, 32'h0000_0307);
    chk(mn, 32'h0000_0226);
    wr(12'h080, 32'h0000_0000);
    wr(12'h0C0, cfg(3'h2, 3'h1, 2'h0, 2'h1, 0, 2'h0));
    tk(3);
    chk(mt, 32'h0000_00C8);
    wr(12'h0D0, 32'hFFFE_7960);
    wr(12'h0C0, cfg(3'h2, 3'h1, 2'h2, 2'h1, 0, 2'h0));
    tk(3);
    chk(mt, 32'hFFFF_3D78);
    wr(12'h0D4, 32'h7FFF_FFFF);
    rv(12'h0D4, 32'h0098_9680);
    wr(12'h0C0, 32'h0000_0000);
  endtask
  task t_gate;
    tg[0] <= 16'h03E8;
    for (int g = 0; g < 3; g++)
      for (int s = 0; s < 2; s++)
      begin
        wr(12'h000, cfg(3'h4, 3'h1, 2'h0, 2'h1, 0, 2'(g)));
        sel_in <= s[0];
        tk(3);
        chk(pr, (g == 0 || g == s + 1) ? 32'h0000_02EE : 0);
      end
    sel_in <= 0;
  endtask
  task t_bip;
    wr(12'h000, cfg(3'h4, 3'h3, 2'h0, 2'h1, 0, 2'h0));
    wr(12'h00C, 32'h0000_03E8);
    tg[0] <= 16'hFE0C;
    for (int i = 0; i < 4; i++)
    begin
      {rr, rl, rot} <= (i == 0) ? 3'b111 : ~(3'b001 << (i - 1));
      tk(3);
      chk(pr, (i == 0) ? 32'hFFFF_FD12 : 0);
    end
    {rr, rl, rot} <= 3'b111;
  endtask
  task t_filt;
    wr(12'h000, cfg(3'h4, 3'h1, 2'h0, 2'h1, 0, 2'h0));
    prmx <= 32'h0000_07D0;
    tg[0] <= 0;
    tk(3);
    wr(12'h018, 32'h0000_000A);
    tg[0] <= 16'h07D0;
    tk(10);
    apb(0, 12'h01C, 0);
    chk(rd >= 32'h0000_04B0 && rd <= 32'h0000_0578, 1);
    tk(41);
    apb(0, 12'h01C, 0);
    chk(rd >= 32'h0000_07C6, 1);
  endtask
  task t_sup;
    setch(0, cfg(3'h4, 3'h0, 2'h0, 2'h1, 0, 2'h0), 0, 0);
    tg[0] <= 16'h00C8;
    tk(3);
    chk({warn, trip}, 0);
    wr(12'h100, 32'h0000_0002);
    tg[0] <= 16'h012C;
    tk(3);
    chk(warn, 0);
    tg[0] <= 16'h012B;
    tk(3);
    chk({warn, trip}, 2);
    wr(12'h100, 32'h0000_0001);
    tk(3);
    chk({warn, trip}, 1);
    rv(12'h104, 32'h0000_0101);
    wr(12'h104, 32'h0000_000F);
    tk(1);
    chk(trip, 1);
    tg[0] <= 16'h0190;
    tk(3);
    chk(trip, 1);
    wr(12'h104, 32'h0000_000F);
    tk(1);
    chk(trip, 0);
    wr(12'h100, 32'h0000_0000);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset;
    t_err;
    t_types;
    t_sum;
    t_func;
    t_gate;
    t_bip;
    t_filt;
    t_sup;
    wrap_up;
  end
endmodule // tb
